// ==== sslt_pkg.sv ====
package sslt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 8;
  localparam int REG_IDX_W = 6;
  localparam int REG_COUNT = 64;
  localparam int PIX_WIDTH = 14;
  localparam int PWM_WIDTH = 12;
  localparam int TR_W      = 10;
  localparam int SUB_W     = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [6:0] REG_STATUS   = 7'h03;
  localparam logic [6:0] REG_CTRL     = 7'h04;
  localparam logic [6:0] REG_MODE     = 7'h05;
  localparam logic [6:0] REG_TR_WIDTH = 7'h0e;
  localparam logic [6:0] REG_GUARD    = 7'h0f;
  localparam logic [6:0] REG_TR_POS   = 7'h10;
  localparam logic [6:0] REG_TR_DROP  = 7'h11;
  localparam logic [6:0] REG_PULSE    = 7'h12;
  localparam logic [6:0] REG_REF_PT   = 7'h18;
  localparam logic [6:0] REG_SIG_PT   = 7'h19;
  localparam logic [6:0] REG_PWM_LO   = 7'h1a;
  localparam logic [6:0] REG_PWM_HI   = 7'h1b;
  localparam logic [6:0] REG_LEND_LO  = 7'h1c;
  localparam logic [6:0] REG_LEND_HI  = 7'h1d;
  localparam logic [6:0] REG_OBEND_LO = 7'h1e;
  localparam logic [6:0] REG_OBEND_HI = 7'h1f;
  localparam logic [6:0] REG_LAMP     = 7'h2c;
  localparam int LAMP_STRIDE = 4;
  localparam int PULSE_STRIDE = 2;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_STANDBY = 2;
  localparam int CTRL_CDS     = 3;
  localparam int CTRL_INVERT  = 4;
  localparam int MODE_ILLUM   = 0;
  localparam int MODE_CHAN    = 2;
  localparam int MODE_CIS     = 4;
  localparam int MODE_GRAY    = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int ADC_DIV        = 8;
  localparam int CH_COUNT       = 3;
  localparam int PIX_CLKS_PIXEL = ADC_DIV * CH_COUNT;
  localparam int PIX_CLKS_LINE  = ADC_DIV;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] COLOR_R = 2'h0;
  localparam logic [1:0] COLOR_G = 2'h1;
  localparam logic [1:0] COLOR_B = 2'h2;

  typedef enum logic [1:0] {
    ILLUM_OFF   = 2'h0,
    ILLUM_WHITE = 2'h1,
    ILLUM_COLOR = 2'h2,
    ILLUM_GRAY  = 2'h3
  } sslt_illum_t;

  typedef enum logic [1:0] {
    CHAN_PIXEL  = 2'h0,
    CHAN_LINE   = 2'h1,
    CHAN_GRAY1  = 2'h2,
    CHAN_COLOR1 = 2'h3
  } sslt_chan_t;

  typedef enum logic [1:0] {
    CIS_OFF    = 2'h0,
    CIS_EDGE   = 2'h1,
    CIS_CENTER = 2'h2,
    CIS_RSVD   = 2'h3
  } sslt_cis_t;

  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_WAIT = 3'b010,
    SCAN_RUN  = 3'b100
  } sslt_scan_t;

endpackage

// ==== sslt_pwm_if.sv ====
`timescale 1ns/1ps
interface sslt_pwm_if
  import sslt_pkg::*;
#(
  parameter int W = PWM_WIDTH
);
  logic [W-1:0] duty;
  logic         enable;
  logic         pwmOut;

  modport ctrl (output duty, output enable, input pwmOut);
  modport gen  (input duty, input enable, output pwmOut);
endinterface

// ==== sslt_pwm.sv ====
`timescale 1ns/1ps
module sslt_pwm
  import sslt_pkg::*;
#(
  parameter int W = PWM_WIDTH
)
(
  input logic        clk,
  input logic        rst,
  sslt_pwm_if.gen    bus
);

  if (W < 1 || W > 16)
  begin : g_bad_width
    $error("sslt_pwm: width out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } sslt_pwm_state_t;

  sslt_pwm_state_t s_q;
  sslt_pwm_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running period of 2**W clocks
  always_comb
  begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + W'(1);
    s_d.out = bus.enable && (s_q.cnt < bus.duty);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.pwmOut = s_q.out;

endmodule

// ==== sslt_top.sv ====
`timescale 1ns/1ps
// Operation
// - Mode zero holds lamps low; reset default.
// - Mode one: red, blue follow on/off pointers.
// - Mode one green is PWM, duty value/4096.
// - PWM counter period spans 4096 clocks.
// - Mode two lights one color per line.
// - Lamp off at off value; beyond-end limits.
// - Mode three pulses all lamps every line.
// - Pixel counter and lamps run unless standby.
// - Scan starts at next line; red in mode two.
// - Without CDS, sample signal, internal reference.
// - Input stage polarity selectable.
// - Pixel pulses reset at line end; clamp raised there.
// - Both transfer pulses share one width register.
// - Zero guardband: transfer and phase align.
// - Edge mode: one shift period at rise.
// - Center mode: one period centered on phase.
// - Pixel rate: mux per conversion, interleaved.
// - Line rate: mux changes once per line.
// - Per channel drop zero to three transfers.
// - Transfer position inside phase high or low.
// - Gray mode uses selected channel coefficients.
module sslt_top
  import sslt_pkg::*;
#(
  parameter int PIX_W = PIX_WIDTH
)
(
  input  logic              clk,
  input  logic              rst,
  input  logic [ADDR_W-1:0] cfgAddr,
  input  logic [DATA_W-1:0] cfgWrData,
  input  logic              cfgWrEn,
  input  logic              cfgRdEn,
  output logic [DATA_W-1:0] cfgRdData,
  output logic              lampRed,
  output logic              lampGreen,
  output logic              lampBlue,
  output logic              transferPulseFirst,
  output logic              transferPulseSecond,
  output logic [2:0]        transferPulse,
  output logic              shiftPhase1,
  output logic              shiftPhase2,
  output logic              resetGatePulse,
  output logic              auxPixelPulseA,
  output logic              auxPixelPulseB,
  output logic              clampActive,
  output logic              sampleRef,
  output logic              sampleSig,
  output logic              useInternalRef,
  output logic              invertInput,
  output logic              adcConvert,
  output logic [1:0]        muxSel,
  output logic [1:0]        coefSel,
  output logic              lineStart,
  output logic              scanActive
);

  if (PIX_W < 2 || PIX_W > 16)
  begin : g_bad_pix
    $error("sslt_top: pixel counter width out of range");
  end

  typedef struct packed {
    logic [REG_COUNT-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0]                rdData;
    logic [SUB_W-1:0]                 pixSub;
    logic [PIX_W-1:0]                 pixCnt;
    logic [2:0]                       adcPh;
    logic [1:0]                       color;
    logic [1:0]                       muxSel;
    logic [1:0]                       coefSel;
    logic [TR_W-1:0]                  trTimer;
    logic [2:0][1:0]                  dropCnt;
    logic [2:0]                       trFire;
    logic [2:0]                       lampLatch;
    logic [2:0]                       lamp;
    sslt_scan_t                       scan;
    logic [2:0]                       transfer;
    logic                             trFirst;
    logic                             trSecond;
    logic                             phase1;
    logic                             phase2;
    logic [2:0]                       pixPulse;
    logic                             clamp;
    logic                             sampleRef;
    logic                             sampleSig;
    logic                             intRef;
    logic                             invert;
    logic                             adcConvert;
    logic                             lineStart;
  } sslt_top_state_t;

  sslt_top_state_t s_q;
  sslt_top_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings
  logic              standby;
  logic              cds;
  sslt_illum_t       illum;
  sslt_chan_t        chan;
  sslt_cis_t         cis;
  logic [1:0]        graySel;
  logic [SUB_W-1:0]  pixLen;
  logic              lastSub;
  logic [PIX_W-1:0]  lineEnd;
  logic [PIX_W-1:0]  obEnd;
  logic              endOfLine;
  logic [PWM_WIDTH-1:0] pwmDuty;
  logic [TR_W-1:0]   wdt;
  logic [TR_W-1:0]   gb;
  logic [TR_W-1:0]   span;
  logic [TR_W-1:0]   pl;
  logic [TR_W-1:0]   t;
  logic              phaseNorm;
  logic              tFirst;
  logic              tSecond;
  logic              phaseNext;
  logic [2:0]        lampOnHit;
  logic [2:0]        lampOffHit;
  logic [2:0]        pulseHit;
  logic [2:0]        trPick;
  logic [DATA_W-1:0] statusByte;
  sslt_pwm_if #(.W(PWM_WIDTH)) pwmBus ();

  assign standby  = s_q.regs[REG_CTRL][CTRL_STANDBY];
  assign cds      = s_q.regs[REG_CTRL][CTRL_CDS];
  assign illum    = sslt_illum_t'(s_q.regs[REG_MODE][MODE_ILLUM +: 2]);
  assign chan     = sslt_chan_t'(s_q.regs[REG_MODE][MODE_CHAN +: 2]);
  assign cis      = sslt_cis_t'(s_q.regs[REG_MODE][MODE_CIS +: 2]);
  assign graySel  = (s_q.regs[REG_MODE][MODE_GRAY +: 2] == 2'h3) ? COLOR_B
                  : s_q.regs[REG_MODE][MODE_GRAY +: 2];
  // Pixel rate mode scans three channels per pixel period
  assign pixLen   = (chan == CHAN_PIXEL) ? SUB_W'(PIX_CLKS_PIXEL)
                  : SUB_W'(PIX_CLKS_LINE);
  assign lastSub  = (s_q.pixSub == pixLen - SUB_W'(1));
  assign lineEnd  = PIX_W'({s_q.regs[REG_LEND_HI], s_q.regs[REG_LEND_LO]});
  assign obEnd    = PIX_W'({s_q.regs[REG_OBEND_HI], s_q.regs[REG_OBEND_LO]});
  // >= so that lowering the line end never strands the counter
  assign endOfLine = lastSub && (s_q.pixCnt >= lineEnd);
  assign pwmDuty  = PWM_WIDTH'({s_q.regs[REG_PWM_HI], s_q.regs[REG_PWM_LO]});

  ////////////////////////////////////////////////////////////////////////////
  // Transfer window, timed from line start
  assign wdt  = TR_W'(s_q.regs[REG_TR_WIDTH]);
  assign gb   = TR_W'(s_q.regs[REG_GUARD][3:0]);
  assign span = wdt + gb + gb;
  assign pl   = TR_W'(pixLen);
  assign t    = s_q.trTimer;
  assign phaseNorm = (s_q.pixSub < (pixLen >> 1));

  always_comb
  begin
    tFirst    = 1'b0;
    tSecond   = 1'b0;
    phaseNext = phaseNorm;
    unique case (cis)
      CIS_EDGE:
      begin
        tFirst = (t < pl);
      end
      CIS_CENTER:
      begin
        tFirst = (t < pl);
        if (t < pl)
        begin
          phaseNext = (t >= (pl >> 2)) && (t < (pl >> 2) + (pl >> 1));
        end
      end
      default:
      begin
        // Zero guard makes both edges coincide
        tFirst  = (t >= gb) && (t < gb + wdt);
        tSecond = (t >= span + gb) && (t < span + gb + wdt);
        if (t < span)
        begin
          phaseNext = 1'b1;
        end
        else if (t < span + span)
        begin
          phaseNext = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-color compares
  for (genvar c = 0; c < 3; c++)
  begin : g_color
    logic [PIX_W-1:0] onVal;
    logic [PIX_W-1:0] offVal;
    logic [SUB_W-1:0] pOn;
    logic [SUB_W-1:0] pOff;
    assign onVal  = PIX_W'({s_q.regs[REG_LAMP + c * LAMP_STRIDE + 1],
                            s_q.regs[REG_LAMP + c * LAMP_STRIDE]});
    assign offVal = PIX_W'({s_q.regs[REG_LAMP + c * LAMP_STRIDE + 3],
                            s_q.regs[REG_LAMP + c * LAMP_STRIDE + 2]});
    // Values past line end never match: lamp stays as it is
    assign lampOnHit[c]  = (s_q.pixCnt == onVal);
    assign lampOffHit[c] = (s_q.pixCnt == offVal);
    assign pOn  = s_q.regs[REG_PULSE + c * PULSE_STRIDE][SUB_W-1:0];
    assign pOff = s_q.regs[REG_PULSE + c * PULSE_STRIDE + 1][SUB_W-1:0];
    assign pulseHit[c] = (s_q.pixSub >= pOn) && (s_q.pixSub < pOff);
    assign trPick[c] = s_q.trFire[c]
                     && (s_q.regs[REG_TR_POS][c] ? tSecond : tFirst);
  end

  assign statusByte = {3'h0, standby, s_q.scan == SCAN_WAIT,
                       s_q.scan == SCAN_RUN, s_q.color};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.lineStart  = 1'b0;
    s_d.adcConvert = 1'b0;

    // Register port
    if (cfgWrEn && !cfgAddr[ADDR_W-1] && cfgAddr != REG_STATUS)
    begin
      s_d.regs[cfgAddr[REG_IDX_W-1:0]] = cfgWrData;
    end
    if (cfgWrEn && cfgAddr == REG_CTRL)
    begin
      if (cfgWrData[CTRL_STOP])
      begin
        s_d.scan = SCAN_IDLE;
      end
      else if (cfgWrData[CTRL_START] && s_q.scan == SCAN_IDLE)
      begin
        s_d.scan = SCAN_WAIT;
      end
    end
    // Start and stop act as strobes only
    s_d.regs[REG_CTRL][CTRL_START] = 1'b0;
    s_d.regs[REG_CTRL][CTRL_STOP]  = 1'b0;
    if (cfgRdEn)
    begin
      if (cfgAddr == REG_STATUS)
      begin
        s_d.rdData = statusByte;
      end
      else if (!cfgAddr[ADDR_W-1])
      begin
        s_d.rdData = s_q.regs[cfgAddr[REG_IDX_W-1:0]];
      end
      else
      begin
        s_d.rdData = REG_RESET;
      end
    end

    // Timing core; frozen only in standby
    if (!standby)
    begin
      s_d.adcPh  = s_q.adcPh + 3'h1;
      s_d.pixSub = lastSub ? '0 : s_q.pixSub + SUB_W'(1);
      if (lastSub)
      begin
        s_d.pixCnt = s_q.pixCnt + PIX_W'(1);
      end
      if (s_q.trTimer != '1)
      begin
        s_d.trTimer = s_q.trTimer + TR_W'(1);
      end
      s_d.adcConvert = (s_q.adcPh == 3'(ADC_DIV - 1));
      if (s_q.pixCnt >= obEnd)
      begin
        s_d.clamp = 1'b0;
      end
      for (int c = 0; c < 3; c++)
      begin
        if (lampOnHit[c])
        begin
          s_d.lampLatch[c] = 1'b1;
        end
        if (lampOffHit[c])
        begin
          s_d.lampLatch[c] = 1'b0;
        end
      end
      if (endOfLine)
      begin
        s_d.pixCnt    = '0;
        s_d.lineStart = 1'b1;
        s_d.trTimer   = '0;
        s_d.adcPh     = '0;
        s_d.clamp     = 1'b1;
        s_d.color = (s_q.color == COLOR_B) ? COLOR_R
                  : s_q.color + 2'h1;
        for (int c = 0; c < 3; c++)
        begin
          // Skipped transfers lengthen this channel's integration
          if (s_q.dropCnt[c] >= s_q.regs[REG_TR_DROP][2 * c +: 2])
          begin
            s_d.dropCnt[c] = 2'h0;
            s_d.trFire[c]  = 1'b1;
          end
          else
          begin
            s_d.dropCnt[c] = s_q.dropCnt[c] + 2'h1;
            s_d.trFire[c]  = 1'b0;
          end
          if (illum == ILLUM_COLOR && s_d.color != 2'(c))
          begin
            s_d.lampLatch[c] = 1'b0;
          end
        end
        if (s_q.scan == SCAN_WAIT
            && (illum != ILLUM_COLOR || s_d.color == COLOR_R))
        begin
          s_d.scan = SCAN_RUN;
        end
      end

      // Channel selection
      unique case (chan)
        CHAN_PIXEL:
        begin
          if (s_d.lineStart)
          begin
            s_d.muxSel = COLOR_R;
          end
          else if (s_d.adcConvert)
          begin
            s_d.muxSel = (s_q.muxSel == COLOR_B) ? COLOR_R
                       : s_q.muxSel + 2'h1;
          end
          s_d.coefSel = s_d.muxSel;
        end
        CHAN_LINE:
        begin
          s_d.muxSel  = s_d.color;
          s_d.coefSel = s_d.color;
        end
        CHAN_GRAY1:
        begin
          s_d.muxSel  = graySel;
          s_d.coefSel = graySel;
        end
        CHAN_COLOR1:
        begin
          // Readout trails the lit color by one line
          s_d.muxSel  = COLOR_B;
          s_d.coefSel = (s_d.color == COLOR_R) ? COLOR_B
                      : s_d.color - 2'h1;
        end
      endcase
    end

    // Registered pins
    unique case (illum)
      ILLUM_OFF:
      begin
        s_d.lamp = 3'h0;
      end
      ILLUM_WHITE:
      begin
        s_d.lamp = {s_q.lampLatch[2], pwmBus.pwmOut,
                    s_q.lampLatch[0]};
      end
      ILLUM_COLOR:
      begin
        for (int c = 0; c < 3; c++)
        begin
          s_d.lamp[c] = s_q.lampLatch[c] && (s_q.color == 2'(c));
        end
      end
      ILLUM_GRAY:
      begin
        s_d.lamp = s_q.lampLatch;
      end
    endcase
    s_d.trFirst   = tFirst;
    s_d.trSecond  = tSecond;
    s_d.transfer  = trPick;
    s_d.phase1    = phaseNext;
    s_d.phase2    = !phaseNext;
    // Pixel pulses held low at line end
    s_d.pixPulse  = (s_q.pixCnt >= lineEnd) ? 3'h0 : pulseHit;
    s_d.sampleRef = cds && (s_q.pixSub == s_q.regs[REG_REF_PT][SUB_W-1:0]);
    s_d.sampleSig = (s_q.pixSub == s_q.regs[REG_SIG_PT][SUB_W-1:0]);
    s_d.intRef    = !cds;
    s_d.invert    = s_q.regs[REG_CTRL][CTRL_INVERT];
    if (standby)
    begin
      s_d.lamp      = 3'h0;
      s_d.trFirst   = 1'b0;
      s_d.trSecond  = 1'b0;
      s_d.transfer  = 3'h0;
      s_d.phase1    = 1'b0;
      s_d.phase2    = 1'b0;
      s_d.pixPulse  = 3'h0;
      s_d.sampleRef = 1'b0;
      s_d.sampleSig = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.scan <= SCAN_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Green lamp PWM

  assign pwmBus.duty   = pwmDuty;
  assign pwmBus.enable = !standby && (illum == ILLUM_WHITE);

  sslt_pwm #(.W(PWM_WIDTH)) uPwm (
    .clk (clk),
    .rst (rst),
    .bus (pwmBus.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfgRdData           = s_q.rdData;
  assign lampRed             = s_q.lamp[0];
  assign lampGreen           = s_q.lamp[1];
  assign lampBlue            = s_q.lamp[2];
  assign transferPulseFirst  = s_q.trFirst;
  assign transferPulseSecond = s_q.trSecond;
  assign transferPulse       = s_q.transfer;
  assign shiftPhase1         = s_q.phase1;
  assign shiftPhase2         = s_q.phase2;
  assign resetGatePulse      = s_q.pixPulse[0];
  assign auxPixelPulseA      = s_q.pixPulse[1];
  assign auxPixelPulseB      = s_q.pixPulse[2];
  assign clampActive         = s_q.clamp;
  assign sampleRef           = s_q.sampleRef;
  assign sampleSig           = s_q.sampleSig;
  assign useInternalRef      = s_q.intRef;
  assign invertInput         = s_q.invert;
  assign adcConvert          = s_q.adcConvert;
  assign muxSel              = s_q.muxSel;
  assign coefSel             = s_q.coefSel;
  assign lineStart           = s_q.lineStart;
  // One-hot code: bit 2 is the run flop itself
  assign scanActive          = s_q.scan[2];

endmodule

// ==== sslt_monitor.sv ====
`timescale 1ns/1ps
module sslt_monitor
  import sslt_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic [DATA_W-1:0] cfgWrData,
  input wire logic              cfgWrEn,
  input wire logic              lampRed,
  input wire logic              lampGreen,
  input wire logic              lampBlue,
  input wire logic              transferPulseFirst,
  input wire logic              transferPulseSecond,
  input wire logic              shiftPhase1,
  input wire logic              useInternalRef,
  input wire logic              adcConvert
);
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [7:0] width_q;
  logic [7:0] guard_q;
  logic [1:0] up_q;
  logic [1:0] quiet_q;

  //////////////////////////////////////////////////////////////////////////
  // Shadow of the settings; strobe bits dropped so they never look stale
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q  <= 8'h00;
      ctrl_q  <= 8'h00;
      width_q <= 8'h00;
      guard_q <= 8'h00;
    end
    else if (cfgWrEn)
    begin
      case (cfgAddr)
        REG_MODE:     mode_q  <= cfgWrData;
        REG_CTRL:     ctrl_q  <= cfgWrData & 8'h1c;
        REG_TR_WIDTH: width_q <= cfgWrData;
        REG_GUARD:    guard_q <= cfgWrData;
        default:      ;
      endcase
    end
  end

  // Outputs are all low for the first edges after reset
  always_ff @(posedge clk)
  begin
    up_q <= rst ? 2'h0 : ((up_q == 2'h3) ? up_q : up_q + 2'h1);
    // A write may cut or start a pulse mid-window
    quiet_q <= (rst || cfgWrEn) ? 2'h0
             : (quiet_q[1] ? quiet_q : quiet_q + 2'h1);
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sHigh4(s);
    s [*4] ##1 !s;
  endsequence

  sequence sHigh8(s);
    s [*8] ##1 !s;
  endsequence

  AST_LAMPS_OFF:
    assert property ((mode_q[1:0] == 2'h0) [*3] |->
      !lampRed && !lampGreen && !lampBlue) else $error("Lamp lit in mode 0");
  AST_ADC_EVERY_8:
    assert property (adcConvert && !ctrl_q[CTRL_STANDBY] |=>
      !adcConvert [*7] ##1 adcConvert) else $error("Converter spacing");
  AST_CDS_REF:
    assert property (up_q == 2'h3 && $stable(ctrl_q) |->
      useInternalRef == !ctrl_q[CTRL_CDS]) else $error("Reference select");
  AST_TR1_WIDTH:
    assert property (disable iff (rst || cfgWrEn)
      $rose(transferPulseFirst) && mode_q[5:4] == 2'h0 && quiet_q[1] &&
      width_q == 8'h04 |-> sHigh4(transferPulseFirst))
      else $error("First transfer width");
  AST_TR2_WIDTH:
    assert property (disable iff (rst || cfgWrEn)
      $rose(transferPulseSecond) && mode_q[5:4] == 2'h0 && quiet_q[1] &&
      width_q == 8'h04 |-> sHigh4(transferPulseSecond))
      else $error("Second transfer width");
  AST_GUARD_ZERO:
    assert property (guard_q[3:0] == 4'h0 && mode_q[5:4] == 2'h0 &&
      $changed(transferPulseFirst) |-> $changed(shiftPhase1) &&
      shiftPhase1 == transferPulseFirst) else $error("Transfer off phase");
  AST_CIS_EDGE:
    assert property (disable iff (rst || cfgWrEn)
      $rose(transferPulseFirst) && mode_q[5:4] == 2'h1 && quiet_q[1] &&
      mode_q[3:2] != 2'h0 |-> sHigh8(transferPulseFirst))
      else $error("Edge mode width");
  AST_CIS_CENTER:
    assert property (disable iff (rst || cfgWrEn)
      $rose(transferPulseFirst) && mode_q[5:4] == 2'h2 && quiet_q[1] &&
      mode_q[3:2] != 2'h0 |-> sHigh8(transferPulseFirst))
      else $error("Center mode width");
endmodule

bind sslt_top sslt_monitor i_sslt_monitor (
  .clk(clk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
  .cfgWrEn(cfgWrEn), .lampRed(lampRed), .lampGreen(lampGreen),
  .lampBlue(lampBlue), .transferPulseFirst(transferPulseFirst),
  .transferPulseSecond(transferPulseSecond), .shiftPhase1(shiftPhase1),
  .useInternalRef(useInternalRef), .adcConvert(adcConvert)
);

// ==== sslt_sensor_model.sv ====
`timescale 1ns/1ps
module sslt_sensor_model
(
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [5:0]  light,
  output logic [5:0][15:0] cnt
);
  // Exposure seen by the sensor; cleared whenever a window is closed
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      cnt[i] <= run ? cnt[i] + 16'(light[i]) : 16'h0000;
    end
  end
endmodule

// ==== sslt_top_tb.sv ====
`timescale 1ns/1ps
module sslt_top_tb
  import sslt_pkg::*;
;
  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] cfgAddr;
  logic [DATA_W-1:0] cfgWrData;
  logic              cfgWrEn;
  logic              cfgRdEn;
  logic [DATA_W-1:0] cfgRdData;
  logic              lampRed, lampGreen, lampBlue, lineStart, run;
  logic              transferPulseFirst, transferPulseSecond;
  logic              useInternalRef, invertInput, scanActive;
  logic [5:0][15:0]  cnt;
  int                mismatches;
  int                checked;

  sslt_top i_sslt_top (
    .clk(clk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData),
    .lampRed(lampRed), .lampGreen(lampGreen), .lampBlue(lampBlue),
    .transferPulseFirst(transferPulseFirst),
    .transferPulseSecond(transferPulseSecond), .transferPulse(),
    .shiftPhase1(), .shiftPhase2(), .resetGatePulse(), .auxPixelPulseA(),
    .auxPixelPulseB(), .clampActive(), .sampleRef(), .sampleSig(),
    .useInternalRef(useInternalRef), .invertInput(invertInput),
    .adcConvert(), .muxSel(), .coefSel(), .lineStart(lineStart),
    .scanActive(scanActive)
  );

  sslt_sensor_model i_sslt_sensor_model (
    .clk(clk), .run(run), .cnt(cnt),
    .light({transferPulseSecond, transferPulseFirst, lineStart, lampBlue,
            lampGreen, lampRed})
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmpReg(input string w, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask

  task automatic cmpCnt(input string w, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    cfgAddr   = a;
    cfgWrData = d;
    cfgWrEn   = 1'b1;
    @(negedge clk);
    cfgWrEn = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(negedge clk);
    cfgRdEn = 1'b0;
    cmpReg($sformatf("reg %h", a), cfgRdData, e);
  endtask

  // Bounded wait; a stuck line counter must not hang the run
  task automatic waitLine();
    int n;
    n = 0;
    @(negedge clk);
    while (lineStart !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Two line starts first, so settings written just before have settled
  task automatic meas(input int n);
    waitLine();
    waitLine();
    run = 1'b1;
    repeat (n) @(negedge clk);
    run = 1'b0;
  endtask

  task automatic lamps(input logic [15:0] r, g, b);
    cmpCnt("red", cnt[0], r);
    cmpCnt("green", cnt[1], g);
    cmpCnt("blue", cnt[2], b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #1000000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    rst        = 1'b1;
    cfgAddr    = 7'h00;
    cfgWrData  = 8'h00;
    cfgWrEn    = 1'b0;
    cfgRdEn    = 1'b0;
    run        = 1'b0;
    mismatches = 0;
    checked    = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd(REG_MODE, 8'h00);
    rd(7'h40, 8'h00);
    wr(REG_TR_WIDTH, 8'h04);
    rd(REG_TR_WIDTH, 8'h04);
    cmpCnt("intref", 16'(useInternalRef), 16'h0001);
    cmpCnt("invert", 16'(invertInput), 16'h0000);
    wr(REG_CTRL, 8'h18);
    @(negedge clk);
    cmpCnt("intref", 16'(useInternalRef), 16'h0000);
    cmpCnt("invert", 16'(invertInput), 16'h0001);
    wr(REG_CTRL, 8'h00);
    wr(REG_REF_PT, 8'h01);
    wr(REG_SIG_PT, 8'h04);
    wr(REG_LEND_LO, 8'h03);
    for (int c = 0; c < 3; c++)
    begin
      wr(REG_LAMP + 7'(LAMP_STRIDE * c), 8'h01);
      wr(REG_LAMP + 7'(LAMP_STRIDE * c + 2), 8'h03);
    end
    wr(REG_MODE, 8'h03);
    meas(288);
    lamps(16'h0090, 16'h0090, 16'h0090);
    cmpCnt("lines", cnt[3], 16'h0003);
    cmpCnt("tr first", cnt[4], 16'h000c);
    cmpCnt("tr second", cnt[5], 16'h000c);
    wr(REG_MODE, 8'h02);
    repeat (2)
    begin
      meas(96);
      cmpCnt("per line", cnt[0] + cnt[1] + cnt[2], 16'h0030);
    end
    meas(288);
    lamps(16'h0030, 16'h0030, 16'h0030);
    wr(REG_LAMP + 7'h02, 8'h0a);
    wr(REG_LAMP + 7'h08, 8'h09);
    wr(REG_MODE, 8'h03);
    meas(288);
    lamps(16'h0120, 16'h0090, 16'h0000);
    wr(REG_PWM_HI, 8'h04);
    wr(REG_MODE, 8'h01);
    meas(4096);
    lamps(16'h1000, 16'h0400, 16'h0000);
    wr(REG_MODE, 8'h00);
    meas(288);
    lamps(16'h0000, 16'h0000, 16'h0000);
    // Guard set non-zero: the contact modes must ignore it
    wr(REG_GUARD, 8'h05);
    wr(REG_MODE, 8'h14);
    meas(96);
    cmpCnt("lines", cnt[3], 16'h0003);
    cmpCnt("tr first", cnt[4], 16'h0018);
    wr(REG_MODE, 8'h24);
    meas(96);
    cmpCnt("tr first", cnt[4], 16'h0018);
    waitLine();
    wr(REG_CTRL, 8'h01);
    cmpCnt("scan", 16'(scanActive), 16'h0000);
    waitLine();
    repeat (2) @(negedge clk);
    cmpCnt("scan", 16'(scanActive), 16'h0001);
    wr(REG_CTRL, 8'h02);
    @(negedge clk);
    cmpCnt("scan", 16'(scanActive), 16'h0000);
    wrap_up();
  end
endmodule
